// ### hw/ppc_defines.svh
// Constants of the printer operator panel controller: offsets, fields, resets, timing.
// Assumes a 125 MHz aclk; included by the controller module.
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// Clock and timing
`define PPC_CLK_NS 8
`define PPC_HOLD_NS 1000000000
`define PPC_HOLD_CYC ((`PPC_HOLD_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_DEB_NS 10000000
`define PPC_DEB_CYC ((`PPC_DEB_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_PAUSE_NS 100000000
`define PPC_PAUSE_CYC ((`PPC_PAUSE_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)

// Register byte offsets
`define PPC_ADDR_CTRL 32'h0000_0000
`define PPC_ADDR_STATUS 32'h0000_0004
`define PPC_ADDR_LEVEL 32'h0000_0008
`define PPC_ADDR_CHARSET 32'h0000_000c

// Control fields and reset
`define PPC_CTRL_KSR_BIT 0
`define PPC_CTRL_FLUSH_BIT 1
`define PPC_CTRL_KSR_RST 1'b0

// Status fields
`define PPC_ST_ONLINE 0
`define PPC_ST_VIEW 1
`define PPC_ST_EMPTY 2
`define PPC_ST_FULL 3
`define PPC_ST_HOME 4
`define PPC_ST_MOVING 5
`define PPC_ST_PAPER_OUT 6
`define PPC_ST_RIBBON_JAM 7
`define PPC_ST_MISC_FAULT 8
`define PPC_ST_PARK 9

// Character-set register fields
`define PPC_CS_STD_LSB 0
`define PPC_CS_ALT_LSB 4
`define PPC_CS_ACTIVE_BIT 8

// Character codes
`define PPC_CODE_PRINT_MIN 7'h20
`define PPC_CODE_SO 7'h0e
`define PPC_CODE_SI 7'h0f
`define PPC_SET_LAST 3'h6

// Bus responses
`define PPC_RESP_OKAY 2'h0
`define PPC_RESP_SLVERR 2'h2

`endif

// ### hw/ppc_pkg.sv
// Types of the printer operator panel controller.
// Widths here are shared by the controller and its bench.
package ppc_pkg;

  localparam int PPC_NPIN = 11;
  localparam int PPC_DEB_W = 21;
  localparam int PPC_TMR_W = 27;
  localparam int PPC_BUF_AW = 8;

  // Panel switches and sensors, bit 10 first
  typedef struct packed {
    logic misc_fault;
    logic ribbon_jam;
    logic paper_out;
    logic motion;
    logic home;
    logic view_key;
    logic view_sw;
    logic feed_key;
    logic feed_pos3;
    logic feed_pos1;
    logic online_btn;
  } ppc_pins_t;

  typedef struct packed {
    logic [6:0] code;
    logic [2:0] set;
  } ppc_prn_t;

  typedef enum logic [1:0] {
    PPC_PR_IDLE = 2'b01,
    PPC_PR_WAIT = 2'b10
  } ppc_pr_st_t;

  typedef enum logic [2:0] {
    PPC_FK_IDLE = 3'b001,
    PPC_FK_HELD = 3'b010,
    PPC_FK_DONE = 3'b100
  } ppc_fk_st_t;

  typedef struct packed {
    ppc_pins_t s1;
    ppc_pins_t s2;
    ppc_pins_t deb;
    logic [PPC_NPIN-1:0][PPC_DEB_W-1:0] db_cnt;
    logic [5:0] cfg_s1;
    logic [5:0] cfg_s2;
    logic online;
    logic view_en;
    logic ksr_mode;
    logic alt_active;
    logic [PPC_BUF_AW-1:0] wr_ptr;
    logic [PPC_BUF_AW-1:0] rd_ptr;
    logic [PPC_BUF_AW:0] count;
    ppc_pr_st_t pr_st;
    ppc_prn_t prn;
    logic prn_valid;
    ppc_fk_st_t fk_st;
    logic [PPC_TMR_W-1:0] fk_cnt;
    logic [PPC_TMR_W-1:0] idle_cnt;
    logic line_feed;
    logic form_feed;
    logic park_req;
    logic host_busy;
    logic online_lamp;
    logic ready_lamp;
    logic fault_lamp;
    logic view_lamp;
    logic [8:0] fire;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ppc_state_t;

endpackage

// ### hw/ppc_panel.sv
// Operator panel, receive buffer and printer state of a serial dot-matrix printer.
// Assumes one 125 MHz clock; pins and switches are asynchronous; the print
// engine, dot columns and host character strobe are on aclk.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ppc_defines.svh"

module ppc_panel #(
  parameter int HOLD_CYC = `PPC_HOLD_CYC,
  parameter int DEB_CYC = `PPC_DEB_CYC,
  parameter int PAUSE_CYC = `PPC_PAUSE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host character stream
  input wire logic host_valid,
  input wire logic [6:0] host_char,
  output logic host_busy,
  // Panel switches, sensors and board switches
  input wire ppc_pkg::ppc_pins_t pins,
  input wire logic [2:0] cfg_std_set,
  input wire logic [2:0] cfg_alt_set,
  // Print engine
  output ppc_pkg::ppc_prn_t prn_req,
  output logic prn_valid,
  input wire logic prn_ready,
  input wire logic [8:0] dot_col,
  input wire logic dot_strobe,
  output logic [8:0] fire,
  // Paper and carriage commands
  output logic line_feed,
  output logic form_feed,
  output logic park_req,
  // Lamps
  output logic online_lamp,
  output logic ready_lamp,
  output logic fault_lamp,
  output logic view_lamp
);
  import ppc_pkg::*;

  localparam int DEPTH = 1 << PPC_BUF_AW;

  ppc_state_t q;
  ppc_state_t nxt;
  logic [6:0] mem [DEPTH];
  logic do_push;

  function automatic logic [2:0] set_clamp(input logic [2:0] sel);
    set_clamp = (sel > `PPC_SET_LAST) ? 3'h0 : sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [PPC_NPIN-1:0] raw;
    logic [PPC_NPIN-1:0] clean;
    ppc_pins_t rise;
    logic fault;
    logic full;
    logic do_pop;
    logic [6:0] pop_code;
    logic [2:0] std_set;
    logic [2:0] alt_set;
    logic idle;
    logic [31:0] rd_word;
    logic rd_ok;
    raw = '0;
    clean = '0;
    rise = '0;
    fault = 1'b0;
    full = 1'b0;
    do_pop = 1'b0;
    pop_code = '0;
    std_set = '0;
    alt_set = '0;
    idle = 1'b0;
    rd_word = '0;
    rd_ok = 1'b0;
    do_push = 1'b0;
    nxt = q;

    // Two-stage synchronisers, then a stable-for-DEB_CYC filter per panel pin (board switches only synchronised)
    nxt.s1 = pins;
    nxt.s2 = q.s1;
    nxt.cfg_s1 = {cfg_alt_set, cfg_std_set};
    nxt.cfg_s2 = q.cfg_s1;
    raw = q.s2;
    clean = q.deb;
    for (int i = 0; i < PPC_NPIN; i++) begin
      if (raw[i] == clean[i]) begin
        nxt.db_cnt[i] = '0;
      end else if (q.db_cnt[i] == PPC_DEB_W'(DEB_CYC - 1)) begin
        nxt.db_cnt[i] = '0;
        clean[i] = raw[i];
      end else begin
        nxt.db_cnt[i] = q.db_cnt[i] + PPC_DEB_W'(1);
      end
    end
    nxt.deb = clean;
    rise = clean & ~q.deb;

    fault = q.deb.paper_out | q.deb.ribbon_jam | q.deb.misc_fault;
    full = q.count[PPC_BUF_AW];
    std_set = set_clamp(q.cfg_s2[2:0]);
    alt_set = set_clamp(q.cfg_s2[5:3]);

    // Online toggle and view feature
    if (rise.online_btn) begin
      nxt.online = ~q.online;
    end
    if (q.ksr_mode) begin
      if (rise.view_key) begin
        nxt.view_en = ~q.view_en;
      end
    end else begin
      nxt.view_en = q.deb.view_sw;
    end

    // Receive buffer fill, online or offline
    do_push = host_valid & ~full;
    if (do_push) begin
      nxt.wr_ptr = q.wr_ptr + PPC_BUF_AW'(1);
    end

    // Buffer drain toward the print engine
    nxt.line_feed = 1'b0;
    nxt.form_feed = 1'b0;
    case (q.pr_st)
      PPC_PR_IDLE: begin
        if (q.online && !fault && q.count != '0) begin
          do_pop = 1'b1;
          pop_code = mem[q.rd_ptr];
          nxt.rd_ptr = q.rd_ptr + PPC_BUF_AW'(1);
          if (pop_code < `PPC_CODE_PRINT_MIN) begin
            if (pop_code == `PPC_CODE_SO) begin
              nxt.alt_active = 1'b1;
            end else if (pop_code == `PPC_CODE_SI) begin
              nxt.alt_active = 1'b0;
            end
          end else begin
            nxt.prn.code = pop_code;
            nxt.prn.set = q.alt_active ? alt_set : std_set;
            nxt.prn_valid = 1'b1;
            nxt.pr_st = PPC_PR_WAIT;
          end
        end
      end
      PPC_PR_WAIT: begin
        if (prn_ready) begin
          nxt.prn_valid = 1'b0;
          nxt.pr_st = PPC_PR_IDLE;
        end
      end
      default: begin
        nxt.prn_valid = 1'b0;
        nxt.pr_st = PPC_PR_IDLE;
      end
    endcase

    case ({do_push, do_pop})
      2'b10: nxt.count = q.count + (PPC_BUF_AW + 1)'(1);
      2'b01: nxt.count = q.count - (PPC_BUF_AW + 1)'(1);
      default: nxt.count = q.count;
    endcase

    // Feed controls: three-position switch or the combined key
    if (!q.ksr_mode) begin
      nxt.line_feed = rise.feed_pos1;
      nxt.form_feed = rise.feed_pos3;
      nxt.fk_st = PPC_FK_IDLE;
    end else begin
      case (q.fk_st)
        PPC_FK_IDLE: begin
          nxt.fk_cnt = '0;
          if (rise.feed_key) begin
            nxt.fk_st = PPC_FK_HELD;
          end
        end
        PPC_FK_HELD: begin
          if (!q.deb.feed_key) begin
            nxt.line_feed = 1'b1;
            nxt.fk_st = PPC_FK_IDLE;
          end else if (q.fk_cnt == PPC_TMR_W'(HOLD_CYC)) begin
            nxt.form_feed = 1'b1;
            nxt.fk_st = PPC_FK_DONE;
          end else begin
            nxt.fk_cnt = q.fk_cnt + PPC_TMR_W'(1);
          end
        end
        PPC_FK_DONE: begin
          if (!q.deb.feed_key) begin
            nxt.fk_st = PPC_FK_IDLE;
          end
        end
        default: nxt.fk_st = PPC_FK_IDLE;
      endcase
    end

    // View parking after a printing pause
    idle = q.online && q.view_en && q.count == '0 && q.pr_st == PPC_PR_IDLE
      && !q.deb.motion;
    if (!idle) begin
      nxt.idle_cnt = '0;
      nxt.park_req = 1'b0;
    end else if (q.idle_cnt == PPC_TMR_W'(PAUSE_CYC - 1)) begin
      nxt.park_req = 1'b1;
    end else begin
      nxt.idle_cnt = q.idle_cnt + PPC_TMR_W'(1);
    end

    // Lamps, busy and dot column
    nxt.online_lamp = nxt.online;
    nxt.host_busy = ~nxt.online | nxt.count[PPC_BUF_AW];
    nxt.ready_lamp = nxt.online & ~fault & ~nxt.count[PPC_BUF_AW];
    nxt.fault_lamp = fault;
    nxt.view_lamp = nxt.view_en;
    nxt.fire = (q.online && dot_strobe) ? dot_col : 9'h000;

    // Write channel: address and data in either order, then response
    if (q.bvalid && s_axi_bready) begin
      nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      nxt.aw_got = 1'b1;
      nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      nxt.w_got = 1'b1;
      nxt.wdata = s_axi_wdata;
      nxt.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = `PPC_RESP_OKAY;
      if (q.awaddr == `PPC_ADDR_CTRL) begin
        if (q.wstrb[0]) begin
          nxt.ksr_mode = q.wdata[`PPC_CTRL_KSR_BIT];
          if (q.wdata[`PPC_CTRL_FLUSH_BIT]) begin
            // Flush drops buffered characters, including one arriving now
            nxt.rd_ptr = '0;
            nxt.wr_ptr = '0;
            nxt.count = '0;
          end
        end
      end else if (q.awaddr != `PPC_ADDR_STATUS && q.awaddr != `PPC_ADDR_LEVEL
                   && q.awaddr != `PPC_ADDR_CHARSET) begin
        nxt.bresp = `PPC_RESP_SLVERR;
      end
    end
    nxt.awready = ~nxt.aw_got & ~nxt.bvalid;
    nxt.wready = ~nxt.w_got & ~nxt.bvalid;

    // Read channel
    if (q.rvalid && s_axi_rready) begin
      nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
        `PPC_ADDR_CTRL: rd_word[`PPC_CTRL_KSR_BIT] = q.ksr_mode;
        `PPC_ADDR_STATUS: begin
          rd_word[`PPC_ST_ONLINE] = q.online;
          rd_word[`PPC_ST_VIEW] = q.view_en;
          rd_word[`PPC_ST_EMPTY] = (q.count == '0);
          rd_word[`PPC_ST_FULL] = full;
          rd_word[`PPC_ST_HOME] = q.deb.home;
          rd_word[`PPC_ST_MOVING] = q.deb.motion;
          rd_word[`PPC_ST_PAPER_OUT] = q.deb.paper_out;
          rd_word[`PPC_ST_RIBBON_JAM] = q.deb.ribbon_jam;
          rd_word[`PPC_ST_MISC_FAULT] = q.deb.misc_fault;
          rd_word[`PPC_ST_PARK] = q.park_req;
        end
        `PPC_ADDR_LEVEL: rd_word[PPC_BUF_AW:0] = q.count;
        `PPC_ADDR_CHARSET: begin
          rd_word[`PPC_CS_STD_LSB +: 3] = std_set;
          rd_word[`PPC_CS_ALT_LSB +: 3] = alt_set;
          rd_word[`PPC_CS_ACTIVE_BIT] = q.alt_active;
        end
        default: rd_ok = 1'b0;
      endcase
      nxt.rvalid = 1'b1;
      nxt.rdata = rd_word;
      nxt.rresp = rd_ok ? `PPC_RESP_OKAY : `PPC_RESP_SLVERR;
    end
    nxt.arready = ~nxt.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ksr_mode <= `PPC_CTRL_KSR_RST;
      q.pr_st <= PPC_PR_IDLE;
      q.fk_st <= PPC_FK_IDLE;
      q.host_busy <= 1'b1;
    end else begin
      q <= nxt;
    end
  end

  // Character storage, written at the push pointer
  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[q.wr_ptr] <= host_char;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign host_busy = q.host_busy;
  assign prn_req = q.prn;
  assign prn_valid = q.prn_valid;
  assign fire = q.fire;
  assign line_feed = q.line_feed;
  assign form_feed = q.form_feed;
  assign park_req = q.park_req;
  assign online_lamp = q.online_lamp;
  assign ready_lamp = q.ready_lamp;
  assign fault_lamp = q.fault_lamp;
  assign view_lamp = q.view_lamp;

endmodule // ppc_panel

// ### tb/ppc_panel_sva.sv
// Assertion checker of the operator panel controller, bound to ppc_panel.
// Assumes one clock aclk and the synchronous active-low reset aresetn.
`timescale 1ns/1ps
`include "ppc_defines.svh"
module ppc_panel_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Host and print engine
  input wire logic host_busy,
  input wire ppc_pkg::ppc_prn_t prn_req,
  input wire logic prn_valid,
  input wire logic prn_ready,
  input wire logic [8:0] dot_col,
  input wire logic dot_strobe,
  input wire logic [8:0] fire,
  // Commands and lamps
  input wire logic line_feed,
  input wire logic form_feed,
  input wire logic park_req,
  input wire logic online_lamp,
  input wire logic ready_lamp,
  input wire logic fault_lamp
);
  import ppc_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  property p_ready;
    ready_lamp |-> online_lamp || $past(online_lamp);
  endproperty
  a_ready: assert property (p_ready) else $error("ready lamp while offline");
  property p_fault;
    fault_lamp && $past(fault_lamp) |-> !ready_lamp;
  endproperty
  a_fault: assert property (p_fault) else $error("ready lamp during fault");
  property p_busy;
    !online_lamp && $past(!online_lamp) |-> host_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy while offline");
  property p_halt;
    $rose(prn_valid) |-> $past(online_lamp);
  endproperty
  a_halt: assert property (p_halt) else $error("print started offline");
  property p_hold;
    prn_valid && !prn_ready |=> prn_valid && $stable(prn_req);
  endproperty
  a_hold: assert property (p_hold) else $error("print request dropped");
  property p_code;
    prn_valid |-> prn_req.code >= `PPC_CODE_PRINT_MIN && prn_req.set != 3'h7;
  endproperty
  a_code: assert property (p_code) else $error("bad code or set printed");
  property p_fire_on;
    dot_strobe && online_lamp |=> fire == $past(dot_col);
  endproperty
  a_fire_on: assert property (p_fire_on) else $error("dot column not fired");
  property p_fire_off;
    !(dot_strobe && online_lamp) |=> fire == 9'h0;
  endproperty
  a_fire_off: assert property (p_fire_off) else $error("wires fired idle");
  property p_feed;
    line_feed || form_feed |=> !(line_feed || form_feed);
  endproperty
  a_feed: assert property (p_feed) else $error("feed pulse too long");
  property p_park;
    park_req |-> $past(online_lamp);
  endproperty
  a_park: assert property (p_park) else $error("parked while offline");
endmodule // ppc_panel_chk

bind ppc_panel ppc_panel_chk u_chk (.aclk(aclk), .aresetn(aresetn), .host_busy(host_busy),
  .prn_req(prn_req), .prn_valid(prn_valid), .prn_ready(prn_ready), .dot_col(dot_col),
  .dot_strobe(dot_strobe), .fire(fire), .line_feed(line_feed), .form_feed(form_feed),
  .park_req(park_req), .online_lamp(online_lamp), .ready_lamp(ready_lamp),
  .fault_lamp(fault_lamp));

// ### tb/ppc_host.sv
// Host computer model: sends bursts of 7-bit characters at a random pace.
// Assumes the bench seeds the random generator and pulses start.
`timescale 1ns/1ps
module ppc_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic [7:0] burst,
  input wire logic start,
  // Character link
  input wire logic host_busy,
  output logic host_valid,
  output logic [6:0] host_char
);
  logic [7:0] left;
  initial begin
    host_valid = 1'h0;
    host_char = 7'h0;
  end
  // Idle data line toggles so stale codes never look valid
  always @(posedge aclk) begin
    host_valid <= 1'h0;
    host_char <= ~host_char;
    if (!aresetn) begin
      left <= 8'h0;
    end else if (start) begin
      left <= burst;
    end else if (left != 8'h0 && $urandom_range(0, 1) == 1) begin
      host_valid <= 1'h1;
      host_char <= ($urandom_range(0, 5) == 0) ? 7'($urandom_range(14, 15)) : 7'($urandom);
      left <= left - 8'h1;
    end
  end
endmodule // ppc_host

// ### tb/testbench.sv
// Self-checking bench of the operator panel controller.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
`include "ppc_defines.svh"
module testbench;
  import ppc_pkg::*;
  localparam int HC = 40;
  localparam int DC = 4;
  localparam int PC = 20;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, start = '0, prn_ready = '0, dot_strobe = '0;
  logic [3:0] s_axi_wstrb = '1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic host_valid, host_busy, prn_valid, line_feed, form_feed, park_req;
  logic online_lamp, ready_lamp, fault_lamp, view_lamp, alt = '0;
  logic [6:0] host_char;
  logic [7:0] burst = '0;
  logic [2:0] cfg_std_set = '0, cfg_alt_set = '0;
  logic [8:0] dot_col = '0, fire;
  ppc_pins_t pins = '0;
  ppc_prn_t prn_req;
  ppc_prn_t exp_q[$];
  int errors = 0, check_count = 0, n_in = 0, lf_n = 0, ff_n = 0, k, v;
  always #4 aclk = ~aclk;
  ppc_panel #(.HOLD_CYC(HC), .DEB_CYC(DC), .PAUSE_CYC(PC)) dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_valid,
    .host_char, .host_busy, .pins, .cfg_std_set, .cfg_alt_set, .prn_req, .prn_valid,
    .prn_ready, .dot_col, .dot_strobe, .fire, .line_feed, .form_feed, .park_req,
    .online_lamp, .ready_lamp, .fault_lamp, .view_lamp);
  ppc_host host (.aclk, .aresetn, .burst, .start, .host_busy, .host_valid, .host_char);
  ////////////////////////////////////////
  function automatic ppc_prn_t exp_prn(input logic [6:0] c);
    return {c, alt ? cfg_alt_set : cfg_std_set};
  endfunction
  function automatic logic [31:0] exp_cs();
    return {23'h0, alt, 1'h0, cfg_alt_set, 1'h0, cfg_std_set};
  endfunction
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (!ok) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [31:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    tmo(s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [31:0] a, m, e);
    rd(a);
    chk(d & m, e);
  endtask
  task automatic wr(input logic [31:0] a, x);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    tmo(s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic press(input int b, n);
    pins[b] <= 1'h1;
    repeat (n) @(posedge aclk);
    pins[b] <= 1'h0;
    repeat (DC + 12) @(posedge aclk);
  endtask
  task automatic fd(input int b, n, el, ef);
    int l0, f0;
    l0 = lf_n;
    f0 = ff_n;
    press(b, n);
    chk({16'(lf_n - l0), 16'(ff_n - f0)}, {16'(el), 16'(ef)});
  endtask
  task automatic send(input logic [7:0] n);
    int i;
    burst <= n;
    start <= 1'h1;
    @(posedge aclk);
    start <= 1'h0;
    @(posedge aclk);
    for (i = 0; i < 3000 && host.left != 8'h0; i++) @(posedge aclk);
    tmo(host.left == 8'h0);
    repeat (4) @(posedge aclk);
  endtask
  task automatic drain;
    int i;
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge aclk);
    tmo(exp_q.size() == 0);
    // Trailing control codes still leave the buffer one per cycle
    repeat (64) @(posedge aclk);
    rdc(`PPC_ADDR_LEVEL, 32'h1ff, 32'h0);
  endtask
  ////////////////////////////////////////
  // Engine stalls and dot columns at random; scoreboard of host traffic
  always @(posedge aclk) begin
    prn_ready <= 1'($urandom_range(0, 1));
    dot_strobe <= 1'($urandom_range(0, 1));
    dot_col <= 9'($urandom);
    lf_n <= lf_n + int'(line_feed);
    ff_n <= ff_n + int'(form_feed);
    if (host_valid) begin
      n_in <= n_in + 1;
      if (host_char >= 7'h20) exp_q.push_back(exp_prn(host_char));
      else if (host_char == `PPC_CODE_SO) alt <= 1'h1;
      else if (host_char == `PPC_CODE_SI) alt <= 1'h0;
    end
    if (prn_valid && prn_ready) chk(prn_req, exp_q.pop_front());
  end
  initial begin
    #700000;
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h7d45));
    cfg_std_set <= 3'($urandom_range(0, 6));
    cfg_alt_set <= 3'($urandom_range(0, 6));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    chk({host_busy, online_lamp, ready_lamp, fault_lamp, view_lamp}, 5'h10);
    rdc(`PPC_ADDR_STATUS, 32'h3ff, 32'h4);
    rd(32'h10);
    chk(r, `PPC_RESP_SLVERR);
    send(8'h0c);
    rdc(`PPC_ADDR_LEVEL, 32'h1ff, n_in);
    chk({prn_valid, host_busy}, 2'h1);
    press(0, 2);
    chk(online_lamp, 1'h0);
    press(0, 10);
    chk({online_lamp, host_busy, ready_lamp}, 3'h5);
    drain();
    send(8'h30);
    drain();
    rdc(`PPC_ADDR_CHARSET, 32'h177, exp_cs());
    for (k = 6; k < 11; k++) begin
      pins[k] <= 1'h1;
      repeat (DC + 12) @(posedge aclk);
      rdc(`PPC_ADDR_STATUS, 32'h1f0, 32'(1 << (k - 2)));
      chk({fault_lamp, ready_lamp}, (k > 7) ? 2'h2 : 2'h1);
      pins[k] <= 1'h0;
      repeat (DC + 12) @(posedge aclk);
    end
    fd(1, 10, 1, 0);
    fd(2, 10, 0, 1);
    pins[4] <= 1'h1;
    repeat (PC + DC + 30) @(posedge aclk);
    chk({park_req, view_lamp}, 2'h3);
    press(0, 10);
    chk({park_req, online_lamp}, 2'h0);
    pins[4] <= 1'h0;
    wr(`PPC_ADDR_CTRL, 32'h1);
    rdc(`PPC_ADDR_CTRL, 32'h3, 32'h1);
    fd(3, 10, 1, 0);
    fd(3, HC + 20, 0, 1);
    for (k = 0; k < 2; k++) begin
      v = int'(view_lamp);
      press(5, 10);
      chk(view_lamp, 1'(!v[0]));
    end
    // Offline overfill: buffer stops at full, then a flush empties it
    send(8'hc8);
    send(8'h50);
    rdc(`PPC_ADDR_LEVEL, 32'h1ff, 32'h100);
    rdc(`PPC_ADDR_STATUS, 32'hc, 32'h8);
    chk({host_busy, ready_lamp}, 2'h2);
    wr(`PPC_ADDR_CTRL, 32'h3);
    chk(r, `PPC_RESP_OKAY);
    exp_q.delete();
    rdc(`PPC_ADDR_LEVEL, 32'h1ff, 32'h0);
    wr(32'h20, 32'h0);
    chk(r, `PPC_RESP_SLVERR);
    rdc(`PPC_ADDR_CTRL, 32'h3, 32'h1);
    complete_run();
  end
endmodule // testbench
